//--- hdl/ddrs_core.sv
`timescale 1ns/1ps
`include "ddrs_map.svh"

// Notes on behaviour
// - each mask bit gates one nine-bit lane
// - mask low both beats stores both bytes
// - mask low one beat stores that byte
// - all masks high leaves location untouched
// - mask differing between beats disables correction
// - correction-disable flag never clears, not by reset
// - load strobe high blocks commands, bursts finish
// - drivers on one cycle from n+2.5
// - off window leaves pin to termination only
// - termination pin low off, high on
// - impedance settled within one millisecond of clocks
// - mask and clock termination follow enable
// - data termination follows enable, and is also off around reads
// - termination off half cycle around drive
// - period counter triggers evaluations and restarts
// - one step per evaluation
// - code selects binary-weighted steps
module ddrs_core #(
  parameter int LANES     = 2,
  parameter int ADDR_W    = 8,
  parameter int CODE_W    = 4,
  parameter int CAL_CYC   = `DDRS_CAL_PERIOD_CYC,
  parameter int PWRUP_CYC = `DDRS_PWRUP_CYC
) (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  // Memory pins
  input  wire logic                 k_i,
  input  wire logic                 k_n_i,
  input  wire logic                 load_strobe_n_i,
  input  wire logic                 rw_i,
  input  wire logic [ADDR_W-1:0]    addr_i,
  input  wire logic [9*LANES-1:0]   dq_i,
  output logic      [9*LANES-1:0]   dq_o,
  output logic                      dq_oe_o,
  input  wire logic [LANES-1:0]     byte_write_mask_n_i,
  input  wire logic                 termination_enable_i,
  input  wire logic                 impedance_reference_pin_i,
  // Termination, impedance and correction flag
  output logic                      dq_term_o,
  output logic                      ctl_term_o,
  output logic [CODE_W-1:0]         imp_code_o,
  output logic                      ecc_off_o,
  // AXI4-Lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  localparam int DW = 9 * LANES;
  localparam int SW = 5 + ADDR_W + DW + LANES;

  // Pin synchronisers, stage one read only by stage two
  logic [SW-1:0]            sy1;
  logic [SW-1:0]            sy2;
  logic                     k_d;
  logic                     kn_d;
  always_ff @(posedge mclk_i) begin
    sy1  <= {k_i, k_n_i, load_strobe_n_i, rw_i, termination_enable_i, addr_i, dq_i, byte_write_mask_n_i};
    sy2  <= sy1;
    k_d  <= sy2[SW-1];
    kn_d <= sy2[SW-2];
  end

  logic                     k_s;
  logic                     kn_s;
  logic                     ld_n_s;
  logic                     rw_s;
  logic                     ten_s;
  logic [ADDR_W-1:0]        addr_s;
  logic [DW-1:0]            dq_s;
  logic [LANES-1:0]         bw_s;
  logic                     k_rise;
  logic                     kn_rise;
  assign {k_s, kn_s, ld_n_s, rw_s, ten_s, addr_s, dq_s, bw_s} = sy2;
  assign k_rise  = k_s && !k_d;
  assign kn_rise = kn_s && !kn_d;

  // Storage: one array per beat, lanes written independently
  logic [DW-1:0]            mem0 [2**ADDR_W];
  logic [DW-1:0]            mem1 [2**ADDR_W];

  // Command pipeline and data path state
  ddrs_pkg::ddrs_cmd_t      cmd_now;
  ddrs_pkg::ddrs_stage_t    p1, p2, p3;
  ddrs_pkg::ddrs_stage_t    next_p1, next_p2, next_p3;
  logic [DW-1:0]            wd0, next_wd0;
  logic [LANES-1:0]         wm0, next_wm0;
  logic [DW-1:0]            rd0, next_rd0;
  logic [DW-1:0]            rd1, next_rd1;
  logic [DW-1:0]            next_dq;
  logic                     next_oe;
  logic                     next_dq_term;
  logic                     wr_commit;
  logic                     half_wr;
  logic                     next_ecc_off;
  logic                     k_run;
  logic                     ecc_off = 1'b0;

  // Deselect folds into the no-op path for driver and termination timing
  always_comb begin
    if (ld_n_s) begin
      cmd_now = ddrs_pkg::CMD_NOP;
    end else begin
      cmd_now = rw_s ? ddrs_pkg::CMD_RD : ddrs_pkg::CMD_WR;
    end
  end

  // Second beat commits the write in the K# half
  assign wr_commit = kn_rise && (p2.cmd == ddrs_pkg::CMD_WR);
  assign half_wr   = wr_commit && ((wm0 ^ bw_s) != '0);

  // Next state of the command pipeline, DQ driver and termination
  always_comb begin
    next_p1      = p1;
    next_p2      = p2;
    next_p3      = p3;
    next_wd0     = wd0;
    next_wm0     = wm0;
    next_rd0     = rd0;
    next_rd1     = rd1;
    next_dq      = dq_o;
    next_oe      = dq_oe_o;
    next_dq_term = dq_term_o;
    // Set gated in reset only: the unreset flop must not latch power-on unknowns
    next_ecc_off = ecc_off | (half_wr && !rst_i);
    if (k_rise) begin
      next_p1 = '{cmd: cmd_now, addr: 8'(addr_s)};
      next_p2 = p1;
      next_p3 = p2;
      if (p1.cmd == ddrs_pkg::CMD_WR) begin
        next_wd0 = dq_s;
        next_wm0 = bw_s;
      end
      // Fetch early so a write committed just before is seen
      if (p1.cmd == ddrs_pkg::CMD_RD) begin
        next_rd0 = mem0[ADDR_W'(p1.addr)];
        next_rd1 = mem1[ADDR_W'(p1.addr)];
      end
      if (p3.cmd == ddrs_pkg::CMD_RD) begin
        next_dq = rd1;
      end
      // Off from n+2 to n+4 brackets the n+2.5..n+3.5 drive
      next_dq_term = ten_s && (p2.cmd != ddrs_pkg::CMD_RD) && (p3.cmd != ddrs_pkg::CMD_RD);
    end else if (kn_rise) begin
      unique case (p3.cmd)
        ddrs_pkg::CMD_RD: begin
          next_dq = rd0;
          next_oe = 1'b1;
        end
        ddrs_pkg::CMD_WR,
        ddrs_pkg::CMD_NOP: begin
          next_oe = 1'b0;
        end
        default: begin
          next_oe = 1'b0;
        end
      endcase
    end
  end

  // Pipeline registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      p1        <= '{cmd: ddrs_pkg::CMD_NOP, addr: 8'h00};
      p2        <= '{cmd: ddrs_pkg::CMD_NOP, addr: 8'h00};
      p3        <= '{cmd: ddrs_pkg::CMD_NOP, addr: 8'h00};
      wd0       <= '0;
      wm0       <= '1;
      rd0       <= '0;
      rd1       <= '0;
      dq_o      <= '0;
      dq_oe_o   <= 1'b0;
      dq_term_o <= 1'b0;
      ctl_term_o <= 1'b0;
      k_run     <= 1'b0;
    end else begin
      p1        <= next_p1;
      p2        <= next_p2;
      p3        <= next_p3;
      wd0       <= next_wd0;
      wm0       <= next_wm0;
      rd0       <= next_rd0;
      rd1       <= next_rd1;
      dq_o      <= next_dq;
      dq_oe_o   <= next_oe;
      dq_term_o <= next_dq_term;
      ctl_term_o <= ten_s;
      k_run     <= k_run | k_rise;
    end
  end

  // Sticky flag: power-on value only, reset leaves it alone
  always_ff @(posedge mclk_i) begin
    ecc_off <= next_ecc_off;
  end
  assign ecc_off_o = ecc_off;

  // Lane writes; an all-high mask writes nothing at all
  always_ff @(posedge mclk_i) begin
    if (wr_commit) begin
      for (int l = 0; l < LANES; l++) begin
        if (!wm0[l]) begin
          mem0[ADDR_W'(p2.addr)][9*l +: 9] <= wd0[9*l +: 9];
        end
        if (!bw_s[l]) begin
          mem1[ADDR_W'(p2.addr)][9*l +: 9] <= dq_s[9*l +: 9];
        end
      end
    end
  end

  // Register file state
  logic                     zq_1;
  logic                     zq_s;
  logic                     cal_done;
  logic [31:0]              ctrl, next_ctrl;
  logic                     aw_v, next_aw_v;
  logic [7:0]               awa, next_awa;
  logic                     w_v, next_w_v;
  logic [31:0]              wdat, next_wdat;
  logic [3:0]               wstb, next_wstb;
  logic                     next_bvalid;
  logic [1:0]               next_bresp;
  logic                     next_rvalid;
  logic [31:0]              next_rdata;
  logic [1:0]               next_rresp;

  // Impedance calibration runs only once K toggles
  ddrs_zq_cal #(
    .CODE_W    (CODE_W),
    .PERIOD    (CAL_CYC),
    .PWRUP_CYC (PWRUP_CYC)
  ) u_cal (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .run_i  (k_run && ctrl[`DDRS_CTRL_CAL_EN_BIT]),
    .cmp_i  (zq_s),
    .code_o (imp_code_o),
    .done_o (cal_done)
  );

  // Reference comparator sync
  always_ff @(posedge mclk_i) begin
    zq_1 <= impedance_reference_pin_i;
    zq_s <= zq_1;
  end

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == `DDRS_CTRL_OFS) begin
      v = ctrl;
    end else if (a == `DDRS_STATUS_OFS) begin
      v[`DDRS_ST_ECC_OFF_BIT]  = ecc_off;
      v[`DDRS_ST_CAL_DONE_BIT] = cal_done;
      v[`DDRS_ST_DQ_TERM_BIT]  = dq_term_o;
      v[`DDRS_ST_CTL_TERM_BIT] = ctl_term_o;
      v[`DDRS_ST_K_RUN_BIT]    = k_run;
      v[`DDRS_ST_CODE_LSB +: CODE_W] = imp_code_o;
    end
    return v;
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    return (a == `DDRS_CTRL_OFS) || (a == `DDRS_STATUS_OFS);
  endfunction

  assign s_axi_awready = !aw_v;
  assign s_axi_wready  = !w_v;
  assign s_axi_arready = !s_axi_rvalid;

  // AXI4-Lite next state; address and data taken in either order
  always_comb begin
    next_ctrl   = ctrl;
    next_aw_v   = aw_v;
    next_awa    = awa;
    next_w_v    = w_v;
    next_wdat   = wdat;
    next_wstb   = wstb;
    next_bvalid = s_axi_bvalid;
    next_bresp  = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_awvalid && !aw_v) begin
      next_aw_v = 1'b1;
      next_awa  = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && !w_v) begin
      next_w_v  = 1'b1;
      next_wdat = s_axi_wdata;
      next_wstb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_v && w_v && !s_axi_bvalid) begin
      next_aw_v   = 1'b0;
      next_w_v    = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = reg_hit(awa) ? `DDRS_RESP_OKAY : `DDRS_RESP_SLVERR;
      if (awa == `DDRS_CTRL_OFS && wstb[0]) begin
        next_ctrl[`DDRS_CTRL_CAL_EN_BIT] = wdat[`DDRS_CTRL_CAL_EN_BIT];
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_axi_rvalid) begin
      next_rvalid = 1'b1;
      next_rdata  = reg_read({s_axi_araddr[7:2], 2'b00});
      next_rresp  = reg_hit({s_axi_araddr[7:2], 2'b00}) ? `DDRS_RESP_OKAY : `DDRS_RESP_SLVERR;
    end
  end

  // AXI4-Lite registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl         <= `DDRS_CTRL_RST;
      aw_v         <= 1'b0;
      awa          <= 8'h00;
      w_v          <= 1'b0;
      wdat         <= 32'h0000_0000;
      wstb         <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DDRS_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `DDRS_RESP_OKAY;
    end else begin
      ctrl         <= next_ctrl;
      aw_v         <= next_aw_v;
      awa          <= next_awa;
      w_v          <= next_w_v;
      wdat         <= next_wdat;
      wstb         <= next_wstb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

  property p_ecc_sticky;
    @(posedge mclk_i) ecc_off |=> ecc_off;
  endproperty
  a_ecc_sticky: assert property (p_ecc_sticky) else $error("correction flag cleared");

  property p_half_sets;
    @(posedge mclk_i) half_wr |=> ecc_off;
  endproperty
  a_half_sets: assert property (p_half_sets) else $error("half write did not set flag");

  property p_deselect_nop;
    @(posedge mclk_i) disable iff (rst_i) (k_rise && ld_n_s) |=> (p1.cmd == ddrs_pkg::CMD_NOP);
  endproperty
  a_deselect_nop: assert property (p_deselect_nop) else $error("command taken with strobe high");

  property p_oe_at_kn;
    @(posedge mclk_i) disable iff (rst_i) $changed(dq_oe_o) |-> $past(kn_rise);
  endproperty
  a_oe_at_kn: assert property (p_oe_at_kn) else $error("driver toggled off the K# edge");

  property p_oe_no_term;
    @(posedge mclk_i) disable iff (rst_i) dq_oe_o |-> !dq_term_o;
  endproperty
  a_oe_no_term: assert property (p_oe_no_term) else $error("termination on while driving");

  property p_term_lead;
    @(posedge mclk_i) disable iff (rst_i) $rose(dq_oe_o) |-> !$past(dq_term_o, 2);
  endproperty
  a_term_lead: assert property (p_term_lead) else $error("termination not off before drive");

  property p_term_pin;
    @(posedge mclk_i) disable iff (rst_i) !ten_s |=> !ctl_term_o && (!dq_term_o || !$past(k_rise));
  endproperty
  a_term_pin: assert property (p_term_pin) else $error("termination on with enable low");

  property p_ctl_term;
    @(posedge mclk_i) disable iff (rst_i) (ten_s ##1 ten_s) |-> ctl_term_o;
  endproperty
  a_ctl_term: assert property (p_ctl_term) else $error("control termination dropped");

endmodule

//--- hdl/ddrs_map.svh
`ifndef DDRS_MAP_SVH
`define DDRS_MAP_SVH

// Register byte offsets
`define DDRS_CTRL_OFS        8'h00
`define DDRS_STATUS_OFS      8'h04

// Control field positions and reset value
`define DDRS_CTRL_CAL_EN_BIT 0
`define DDRS_CTRL_RST        32'h0000_0001

// Status field positions
`define DDRS_ST_ECC_OFF_BIT  0
`define DDRS_ST_CAL_DONE_BIT 1
`define DDRS_ST_DQ_TERM_BIT  2
`define DDRS_ST_CTL_TERM_BIT 3
`define DDRS_ST_K_RUN_BIT    4
`define DDRS_ST_CODE_LSB     8

// AXI responses
`define DDRS_RESP_OKAY       2'h0
`define DDRS_RESP_SLVERR     2'h2

// Timing
`define DDRS_MCLK_MHZ        200
`define DDRS_PWRUP_TIME_US   1000
`define DDRS_PWRUP_CYC       (`DDRS_PWRUP_TIME_US * `DDRS_MCLK_MHZ)
`define DDRS_CAL_PERIOD_CYC  1024

`endif

//--- hdl/ddrs_pkg.sv
package ddrs_pkg;

  // Command captured at a K rise
  typedef enum logic [2:0] {
    CMD_NOP = 3'b001,
    CMD_WR  = 3'b010,
    CMD_RD  = 3'b100
  } ddrs_cmd_t;

  // One pipeline stage of the command path
  typedef struct packed {
    ddrs_cmd_t  cmd;
    logic [7:0] addr;
  } ddrs_stage_t;

endpackage

//--- hdl/ddrs_zq_cal.sv
`timescale 1ns/1ps
`include "ddrs_map.svh"

module ddrs_zq_cal #(
  parameter int CODE_W    = 4,
  parameter int PERIOD    = `DDRS_CAL_PERIOD_CYC,
  parameter int PWRUP_CYC = `DDRS_PWRUP_CYC
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  // Control
  input  wire logic              run_i,
  input  wire logic              cmp_i,
  // Result
  output logic [CODE_W-1:0]      code_o,
  output logic                   done_o
);

  logic [31:0]       cnt;
  logic [31:0]       next_cnt;
  logic [31:0]       pwr;
  logic [31:0]       next_pwr;
  logic [CODE_W-1:0] next_code;
  logic              eval;

  // Period counter, held while run_i is low, one step per evaluation
  always_comb begin
    eval      = run_i && (cnt == 32'(PERIOD - 1));
    next_cnt  = eval ? 32'h0000_0000 : (run_i ? cnt + 32'h0000_0001 : cnt);
    next_pwr  = (run_i && !done_o) ? pwr + 32'h0000_0001 : pwr;
    next_code = code_o;
    // Binary-weighted code, saturates at both ends
    if (eval) begin
      if (cmp_i && !(&code_o)) begin
        next_code = code_o + 1'b1;
      end else if (!cmp_i && (|code_o)) begin
        next_code = code_o - 1'b1;
      end
    end
  end

  // Power-up settle is judged by elapsed cycles, not by code stability
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt    <= 32'h0000_0000;
      pwr    <= 32'h0000_0000;
      code_o <= CODE_W'(1) << (CODE_W - 1);
      done_o <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      pwr    <= next_pwr;
      code_o <= next_code;
      done_o <= done_o | (next_pwr >= 32'(PWRUP_CYC));
    end
  end

  property p_step_one;
    @(posedge mclk_i) disable iff (rst_i)
      (code_o != $past(code_o)) |-> ((code_o == $past(code_o) + 1'b1) || (code_o == $past(code_o) - 1'b1));
  endproperty
  a_step_one: assert property (p_step_one) else $error("code moved more than one step");

  property p_step_on_eval;
    @(posedge mclk_i) disable iff (rst_i)
      (code_o != $past(code_o)) |-> $past(eval);
  endproperty
  a_step_on_eval: assert property (p_step_on_eval) else $error("code changed without evaluation");

endmodule

//--- tb/ddrs_ctl_model.sv
`timescale 1ns/1ps
module ddrs_ctl_model (
  // Clock
  input  wire logic        mclk_i,
  // Clock and command pins
  output logic             k_o,
  output logic             k_n_o,
  output logic             load_strobe_n_o,
  output logic             rw_o,
  output logic [7:0]       addr_o,
  // Data pins
  output logic [17:0]      dq_o,
  output logic [1:0]       mask_n_o,
  input  wire logic [17:0] dev_dq_i,
  input  wire logic        dev_oe_i,
  input  wire logic        dev_term_i
);
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        ds;
    logic [7:0]  a;
    logic [17:0] d0;
    logic [17:0] d1;
    logic [1:0]  m0;
    logic [1:0]  m1;
  } ddrs_op_t;

  ddrs_op_t    q[$];
  logic [19:0] rq[$];
  ddrs_op_t    hist [4] = '{default: '0};
  ddrs_op_t    cur;
  logic [4:0]  ph = 5'h00;
  logic [4:0]  nph;
  logic        drv = 1'b0;
  logic [17:0] wd = 18'h00000;

  // Empty queue means deselect with read level low
  task automatic push_op(input logic rd, input logic wr, input logic ds, input logic [7:0] a,
                         input logic [17:0] d0, input logic [17:0] d1, input logic [1:0] m0,
                         input logic [1:0] m1);
    q.push_back({rd, wr, ds, a, d0, d1, m0, m1});
  endtask

  // Released line shows the inverse of its last level, never a stale copy
  assign dq_o = dev_oe_i ? dev_dq_i : (drv ? wd : ~wd);
  assign nph = ph + 5'h01;

  initial {k_o, k_n_o, load_strobe_n_o, rw_o, addr_o, mask_n_o} = {4'b0110, 8'h00, 2'h3};

  // K rises at phase 0, K# at 16; pins move at 8 and 24, far from both edges
  always @(posedge mclk_i) begin
    ph <= nph;
    k_o <= ~nph[4];
    k_n_o <= nph[4];
    if (ph == 5'h18) begin
      cur = (q.size() > 0) ? q.pop_front() : '0;
      hist[0] <= cur;
      hist[1] <= hist[0];
      hist[2] <= hist[1];
      hist[3] <= hist[2];
      load_strobe_n_o <= ~(cur.rd | cur.wr);
      rw_o <= cur.rd | cur.ds;
      addr_o <= cur.a;
      drv <= hist[0].wr;
      wd <= hist[0].wr ? hist[0].d0 : wd;
      mask_n_o <= hist[0].wr ? hist[0].m0 : 2'h3;
    end
    if (ph == 5'h08) begin
      drv <= hist[1].wr;
      wd <= hist[1].wr ? hist[1].d1 : wd;
      mask_n_o <= hist[1].wr ? hist[1].m1 : 2'h3;
    end
    // Read beats taken mid-window
    if ((ph == 5'h1C || ph == 5'h0C) && hist[3].rd)
      rq.push_back({dev_oe_i, dev_term_i, dev_dq_i});
  end
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        term_en = 1'b0;
  logic        cmp = 1'b1;
  logic        k, k_n, lsn, rw, oe, dq_term, ctl_term, ecc_off, prev_rst;
  logic [7:0]  addr;
  logic [17:0] dq_line, dq_dev;
  logic [1:0]  mask_n, bresp, rresp;
  logic [3:0]  code, prev_code;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic        awrdy, wrdy, bv, ardy, rv;
  int          miscompares = 0, n_checks = 0, cyc = 0, oe_cnt = 0;

  initial forever #2.5 mclk_i = ~mclk_i;

  // Short power-up and calibration counts keep the run brief
  ddrs_core #(.CAL_CYC(8), .PWRUP_CYC(200)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .k_i(k), .k_n_i(k_n), .load_strobe_n_i(lsn), .rw_i(rw),
    .addr_i(addr), .dq_i(dq_line), .dq_o(dq_dev), .dq_oe_o(oe), .byte_write_mask_n_i(mask_n),
    .termination_enable_i(term_en), .impedance_reference_pin_i(cmp), .dq_term_o(dq_term),
    .ctl_term_o(ctl_term), .imp_code_o(code), .ecc_off_o(ecc_off),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(ardy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rready));

  ddrs_ctl_model ctl (
    .mclk_i(mclk_i), .k_o(k), .k_n_o(k_n), .load_strobe_n_o(lsn), .rw_o(rw), .addr_o(addr),
    .dq_o(dq_line), .mask_n_o(mask_n), .dev_dq_i(dq_dev), .dev_oe_i(oe), .dev_term_i(dq_term));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Driver-on cycle count, code step watch and hang limit
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    oe_cnt <= oe_cnt + ((oe === 1'b1) ? 1 : 0);
    prev_code <= code;
    prev_rst <= rst_i;
    if (!rst_i && !prev_rst && code !== prev_code)
      chk("code_step", 32'h1, {28'h0, (code > prev_code) ? code - prev_code : prev_code - code});
    if (cyc == 90000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    t = 0;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      t++;
      if (awrdy === 1'b1) awv <= 1'b0;
      if (wrdy === 1'b1) wv <= 1'b0;
    end while (((awv && awrdy !== 1'b1) || (wv && wrdy !== 1'b1)) && t < 100);
    do begin
      @(posedge mclk_i);
      t++;
    end while (bv !== 1'b1 && t < 200);
    bready <= 1'b0;
    chk("bresp", {29'h0, 1'b1, er}, {29'h0, bv, bresp});
    tick(1);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic [1:0] er);
    int t;
    t = 0;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk_i);
      t++;
    end while (ardy !== 1'b1 && t < 100);
    arv <= 1'b0;
    do begin
      @(posedge mclk_i);
      t++;
    end while (rv !== 1'b1 && t < 200);
    rready <= 1'b0;
    chk("rresp", {29'h0, 1'b1, er}, {29'h0, rv, rresp});
    chk("rdata", e, rdata & m);
    tick(1);
  endtask

  task automatic mem_wr(input logic [7:0] a, input logic [17:0] d0, input logic [17:0] d1,
                        input logic [1:0] m0, input logic [1:0] m1);
    ctl.push_op(1'b0, 1'b1, 1'b0, a, d0, d1, m0, m1);
  endtask

  // Both beats must come with drivers on and termination off
  task automatic mem_rd(input logic [7:0] a, input logic [17:0] e0, input logic [17:0] e1);
    logic [19:0] b;
    int t;
    t = 0;
    ctl.push_op(1'b1, 1'b0, 1'b0, a, 18'h0, 18'h0, 2'h3, 2'h3);
    while (ctl.rq.size() < 2 && t < 1000) begin
      tick(1);
      t++;
    end
    for (int i = 0; i < 2; i++) begin
      b = (ctl.rq.size() > 0) ? ctl.rq.pop_front() : 20'h0;
      chk("read_beat", {12'h0, 2'b10, (i == 0) ? e0 : e1}, {12'h0, b});
    end
  endtask

  // Reset values and unmapped access
  task automatic t_reset();
    chk("pins_reset", 32'h20, {26'h0, code, oe, dq_term});
    axi_rd(8'h00, 32'hFFFFFFFF, 32'h1, 2'h0);
    axi_rd(8'h04, 32'h0F0D, 32'h0800, 2'h0);
    axi_wr(8'h08, 32'h1, 2'h2);
    axi_rd(8'h08, 32'hFFFFFFFF, 32'h0, 2'h2);
  endtask

  // Lane masks per beat, abort, half write and its sticky flag
  task automatic t_mask();
    logic [17:0] a0 = 18'h1A2B3;
    logic [17:0] a1 = 18'h0C0DE;
    mem_wr(8'h03, a0, a1, 2'h0, 2'h0);
    mem_rd(8'h03, a0, a1);
    mem_wr(8'h03, 18'h3FFFF, 18'h3FFFF, 2'h2, 2'h2);
    mem_rd(8'h03, {a0[17:9], 9'h1FF}, {a1[17:9], 9'h1FF});
    mem_wr(8'h03, 18'h0, 18'h0, 2'h3, 2'h3);
    mem_rd(8'h03, {a0[17:9], 9'h1FF}, {a1[17:9], 9'h1FF});
    chk("ecc_off", 32'h0, {31'h0, ecc_off});
    mem_wr(8'h03, 18'h15555, 18'h2AAAA, 2'h1, 2'h2);
    mem_rd(8'h03, {9'h0AA, 9'h1FF}, {a1[17:9], 9'h0AA});
    chk("ecc_off", 32'h1, {31'h0, ecc_off});
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(4);
    chk("ecc_off", 32'h1, {31'h0, ecc_off});
    axi_rd(8'h04, 32'h1, 32'h1, 2'h0);
  endtask

  // Termination follows its enable; drivers on only for read beats
  task automatic t_term();
    int c0;
    tick(64);
    chk("term_off", 32'h0, {30'h0, ctl_term, dq_term});
    term_en <= 1'b1;
    tick(64);
    chk("term_idle", 32'h6, {29'h0, ctl_term, dq_term, oe});
    c0 = oe_cnt;
    mem_wr(8'h09, 18'h2468A, 18'h13579, 2'h0, 2'h0);
    mem_rd(8'h09, 18'h2468A, 18'h13579);
    tick(128);
    chk("oe_cycles", 32'd32, 32'(oe_cnt - c0));
    c0 = oe_cnt;
    repeat (3) ctl.push_op(1'b0, 1'b0, 1'b1, 8'h09, 18'h0, 18'h0, 2'h3, 2'h3);
    tick(256);
    chk("oe_deselect", 32'h0, 32'(oe_cnt - c0));
    chk("term_idle", 32'h6, {29'h0, ctl_term, dq_term, oe});
  endtask

  task automatic wait_code(input logic [3:0] v);
    for (int t = 0; t < 30000 && code !== v; t++) tick(1);
  endtask

  // Code walks toward the comparator and holds when calibration is off
  task automatic t_cal();
    logic [3:0] c;
    wait_code(4'hF);
    chk("code_up", 32'hF, {28'h0, code});
    axi_rd(8'h04, 32'h2, 32'h2, 2'h0);
    cmp <= 1'b0;
    wait_code(4'h0);
    chk("code_down", 32'h0, {28'h0, code});
    axi_wr(8'h00, 32'h0, 2'h0);
    c = code;
    cmp <= 1'b1;
    tick(2000);
    chk("code_hold", {28'h0, c}, {28'h0, code});
    axi_rd(8'h00, 32'hFFFFFFFF, 32'h0, 2'h0);
  endtask

  initial begin
    tick(10);
    rst_i <= 1'b0;
    tick(4);
    t_reset();
    t_mask();
    t_term();
    t_cal();
    wrap_up();
  end
endmodule
